// [pkg/tmr_pkg.sv]
// constants and types for one capture/compare timer channel
package tmr_pkg;
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 8;
	// register offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CNT = 8'h0c;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_PRESC = 8'h14;
	localparam logic [7:0] OFS_IRQ = 8'h18;
	localparam logic [7:0] OFS_MASK = 8'h1c;
	// mode register fields
	localparam int unsigned M_CKS_HI = 15;
	localparam int unsigned M_CKS_LO = 14;
	localparam int unsigned M_CCS = 12;
	localparam int unsigned M_ROLE = 11;
	localparam int unsigned M_CIS_HI = 7;
	localparam int unsigned M_CIS_LO = 6;
	localparam int unsigned M_MD_HI = 3;
	localparam int unsigned M_MD_LO = 1;
	localparam int unsigned M_MD0 = 0;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] MODE_RUN_WMASK = 16'h00c0;
	localparam logic [15:0] MODE_NOROLE_MASK = 16'hf7ff;
	// control, status and interrupt bits
	localparam int unsigned C_START = 0;
	localparam int unsigned C_STOP = 1;
	localparam int unsigned C_FILTER = 2;
	localparam int unsigned S_ENABLE = 0;
	localparam int unsigned S_FIRST = 1;
	localparam int unsigned I_CAPTURE = 0;
	localparam int unsigned I_START = 1;
	localparam int unsigned I_INTERVAL = 2;
	localparam int unsigned IRQ_W = 3;
	// prescaler select fields; bits 15,14,11,10 always read zero
	localparam int unsigned P_CK0_LO = 0;
	localparam int unsigned P_CK1_LO = 4;
	localparam int unsigned P_CK2_LO = 8;
	localparam int unsigned P_CK3_LO = 12;
	localparam logic [15:0] PRESC_WMASK = 16'h33ff;
	localparam logic [15:0] PRESC_RESET = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	// division exponents of the two extra prescaler outputs
	localparam logic [3:0] CK2_EXP [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
	localparam logic [3:0] CK3_EXP [4] = '{4'h8, 4'ha, 4'hc, 4'he};

	typedef enum logic [2:0] {
		MD_INTERVAL = 3'h0,
		MD_CAPTURE = 3'h2,
		MD_EVENT = 3'h3,
		MD_ONECOUNT = 3'h4,
		MD_CAPONE = 3'h6
	} opmode_t;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_BOTH_ALT = 2'h3
	} edge_t;

	typedef enum logic [1:0] {
		CH_IDLE = 2'h0,
		CH_WAIT = 2'h1,
		CH_RUN = 2'h2
	} chan_st_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [15:0] mode;
		logic filterOn;
		chan_st_t st;
		logic [15:0] counter;
		logic [15:0] data;
		logic firstCap;
		logic [2:0] irqStat;
		logic [2:0] irqMask;
		logic [15:0] presc;
		logic sync1;
		logic sync2;
		logic fltA;
		logic fltB;
		logic prevLvl;
		logic [15:0] rdata;
	} chan_state_t;

	typedef struct packed {
		logic [15:0] cnt;
	} presc_state_t;
endpackage

// [logic/prescale_gen.sv]
// divider that turns the system clock into one-cycle count enables
`timescale 1ns/1ps
`default_nettype none
module prescale_gen (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// divider selects
	input wire logic [3:0] sel0,
	input wire logic [3:0] sel1,
	input wire logic [1:0] sel2,
	input wire logic [1:0] sel3,
	// enable pulses, one mclk period wide
	output logic [3:0] tick
);
	tmr_pkg::presc_state_t s;
	tmr_pkg::presc_state_t next_s;
	logic [15:0] tap;

	// tap k is high once in every 2^k cycles; a pulse, not a divided clock
	assign tap[0] = 1'b1;
	for (genvar k = 1; k < 16; k++)
	begin : g_tap
		assign tap[k] = &s.cnt[k-1:0]; // [R15]
	end

	always_comb
	begin
		next_s = s;
		if (ce)
			next_s.cnt = s.cnt + tmr_pkg::ONE16;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			s <= '0;
		else
			s <= next_s;
	end

	// gated with ce so a frozen block never sees a count enable
	assign tick[0] = ce & tap[sel0];
	assign tick[1] = ce & tap[sel1];
	assign tick[2] = ce & tap[tmr_pkg::CK2_EXP[sel2]]; // [R14]
	assign tick[3] = ce & tap[tmr_pkg::CK3_EXP[sel3]];

	a_tick_one_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
		(tick[2] && ce) |=> !tick[2]) // [R15]
		else $error("prescaler enable wider than one cycle");
endmodule
`default_nettype wire

// [logic/timer_channel_capture.sv]
// one timer channel: mode register, count enables, capture and interval modes
//
// Behaviour
// R1: writing one to the start bit sets the enable status bit.
// R2: after enabling, the counter holds its old value until a count enable.
// R3: first count enable after start is the trigger; counter loads zero, counts up.
// R4: with start-interrupt bit set, the start trigger raises the channel interrupt.
// R5: each valid input edge copies the counter to the data register and interrupts.
// R6: after each capture the counter restarts from zero and keeps counting.
// R7: the first capture after start is meaningless; software discards it.
// R8: noise filter on delays edge detection by two operation-clock cycles.
// R9: software must not rewrite the mode register while enabled.
// R10: mode bits seven and six stay writable while the channel runs.
// R11: mode register is 16 bits, written whole, reset to zero.
// R12: bit eleven is master, split, or fixed zero depending on channel.
// R13: mode selects clocks, role, triggers, edge and operating mode.
// R14: channels 1 and 3 may use the two extra prescaler outputs.
// R15: prescaler selections are one-cycle enable pulses, not divided clocks.
// R16: with undivided clock and zero data, software must not rely on interrupts.
// R17: software writes zero to prescaler select bits 15, 14, 11, 10.
// R18: in capture mode the counter increments by one per count enable.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_capture #(
	parameter int unsigned CHANNEL = 1
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// register port
	input wire tmr_pkg::bus_req_t busReq,
	output logic [15:0] readData,
	// timer input pin
	input wire logic captureInputPin,
	// channel outputs
	output logic channelInterrupt,
	output logic channelEnableStatus
);
	tmr_pkg::chan_state_t s;
	tmr_pkg::chan_state_t next_s;
	logic [3:0] tick;
	logic [1:0] cks;
	logic opEn;
	logic lvl;
	logic rise;
	logic fall;
	logic validEdge;
	logic cntPulse;
	logic splitCapable;
	logic [15:0] modeWmask;
	logic wrMode;
	logic wrCtrl;
	tmr_pkg::opmode_t md;
	tmr_pkg::edge_t cis;
	logic [2:0] irqSet;
	logic [2:0] irqClr;

	// bit eleven exists only on some channels [R12]
	assign splitCapable = (CHANNEL == 1) || (CHANNEL == 3);
	assign modeWmask = (CHANNEL == 0 || CHANNEL == 5 || CHANNEL == 7)
		? tmr_pkg::MODE_NOROLE_MASK : 16'hffff;

	prescale_gen u_presc (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.sel0(s.presc[tmr_pkg::P_CK0_LO +: 4]),
		.sel1(s.presc[tmr_pkg::P_CK1_LO +: 4]),
		.sel2(s.presc[tmr_pkg::P_CK2_LO +: 2]),
		.sel3(s.presc[tmr_pkg::P_CK3_LO +: 2]),
		.tick(tick)
	);

	// operation clock choice; extra outputs fall back to the first on other channels
	always_comb
	begin
		cks = s.mode[tmr_pkg::M_CKS_HI:tmr_pkg::M_CKS_LO];
		case (cks) // [R13]
			2'h0: opEn = tick[0];
			2'h2: opEn = tick[1];
			2'h1: opEn = splitCapable ? tick[2] : tick[0]; // [R14]
			2'h3: opEn = splitCapable ? tick[3] : tick[0]; // [R14]
			default: opEn = tick[0];
		endcase
	end

	// mode fields and edge detection on the filtered input level
	assign md = tmr_pkg::opmode_t'(s.mode[tmr_pkg::M_MD_HI:tmr_pkg::M_MD_LO]);
	assign cis = tmr_pkg::edge_t'(s.mode[tmr_pkg::M_CIS_HI:tmr_pkg::M_CIS_LO]);
	assign lvl = s.filterOn ? s.fltB : s.sync2; // [R8]
	assign rise = lvl & ~s.prevLvl;
	assign fall = ~lvl & s.prevLvl;
	always_comb
	begin
		case (cis) // [R13]
			tmr_pkg::EDGE_FALL: validEdge = ce & fall;
			tmr_pkg::EDGE_RISE: validEdge = ce & rise;
			default: validEdge = ce & (rise | fall);
		endcase
	end

	// event counter mode and the count-source bit make input edges the start trigger and the down-count pulse
	assign cntPulse = (s.mode[tmr_pkg::M_CCS] || md == tmr_pkg::MD_EVENT) ? validEdge : opEn;

	assign wrMode = busReq.wr && busReq.addr == tmr_pkg::OFS_MODE;
	assign wrCtrl = busReq.wr && busReq.addr == tmr_pkg::OFS_CTRL;
	assign irqClr = (busReq.wr && busReq.addr == tmr_pkg::OFS_IRQ) ? busReq.wdata[2:0] : 3'h0;

	// all channel state advances here
	always_comb
	begin
		next_s = s;
		irqSet = 3'h0;
		if (ce)
		begin
			// pin sync; the first flop feeds only the second
			next_s.sync1 = captureInputPin;
			next_s.sync2 = s.sync1;
			next_s.prevLvl = lvl;
			// two extra operation-clock stages when the filter is on
			if (opEn)
			begin
				next_s.fltA = s.sync2; // [R8]
				next_s.fltB = s.fltA;
			end
			// full write only while stopped; edge select always writable
			if (wrMode)
			begin
				if (s.st == tmr_pkg::CH_IDLE)
					next_s.mode = busReq.wdata & modeWmask; // [R11] [R12]
				else
					next_s.mode = (s.mode & ~tmr_pkg::MODE_RUN_WMASK)
						| (busReq.wdata & tmr_pkg::MODE_RUN_WMASK); // [R10]
			end
			if (busReq.wr && busReq.addr == tmr_pkg::OFS_DATA)
				next_s.data = busReq.wdata;
			if (busReq.wr && busReq.addr == tmr_pkg::OFS_PRESC)
				next_s.presc = busReq.wdata & tmr_pkg::PRESC_WMASK; // [R17]
			if (busReq.wr && busReq.addr == tmr_pkg::OFS_MASK)
				next_s.irqMask = busReq.wdata[2:0];
			if (wrCtrl)
				next_s.filterOn = busReq.wdata[tmr_pkg::C_FILTER];
			case (s.st)
				tmr_pkg::CH_IDLE:
				begin
					if (wrCtrl && busReq.wdata[tmr_pkg::C_START])
					begin
						next_s.st = tmr_pkg::CH_WAIT; // [R1]
						next_s.firstCap = 1'b1; // [R7]
					end
				end
				tmr_pkg::CH_WAIT:
				begin
					// counter keeps its old value until the trigger [R2]
					if (cntPulse)
					begin
						next_s.st = tmr_pkg::CH_RUN;
						if (md == tmr_pkg::MD_CAPTURE)
							next_s.counter = tmr_pkg::ZERO16; // [R3]
						else
							next_s.counter = s.data;
						irqSet[tmr_pkg::I_START] = s.mode[tmr_pkg::M_MD0]; // [R4]
					end
				end
				tmr_pkg::CH_RUN:
				begin
					case (md)
						tmr_pkg::MD_CAPTURE:
						begin
							// a capture beats a count enable in the same cycle
							if (validEdge)
							begin
								next_s.data = s.counter; // [R5]
								next_s.counter = tmr_pkg::ZERO16; // [R6]
								next_s.firstCap = 1'b0;
								irqSet[tmr_pkg::I_CAPTURE] = 1'b1; // [R5]
							end
							else if (opEn)
								next_s.counter = s.counter + tmr_pkg::ONE16; // [R18]
						end
						tmr_pkg::MD_INTERVAL, tmr_pkg::MD_EVENT:
						begin
							// down counter reloads from data and interrupts at zero
							if (cntPulse)
							begin
								if (s.counter == tmr_pkg::ZERO16)
								begin
									next_s.counter = s.data;
									irqSet[tmr_pkg::I_INTERVAL] = 1'b1;
								end
								else
									next_s.counter = s.counter - tmr_pkg::ONE16;
							end
						end
						default:
						begin
							// one-count modes hold the counter in this channel
							next_s.counter = s.counter;
						end
					endcase
				end
				default:
					next_s.st = tmr_pkg::CH_IDLE;
			endcase
			// stop clears the enable; a start in the same write from idle sets only the first-capture flag
			if (wrCtrl && busReq.wdata[tmr_pkg::C_STOP])
				next_s.st = tmr_pkg::CH_IDLE;
			// sticky status, set wins over a write-one clear
			next_s.irqStat = (s.irqStat & ~irqClr) | irqSet;
			// read data lives only in the cycle after the strobe
			next_s.rdata = tmr_pkg::ZERO16;
			if (busReq.rd)
			begin
				case (busReq.addr)
					tmr_pkg::OFS_MODE: next_s.rdata = s.mode;
					tmr_pkg::OFS_CTRL: next_s.rdata = {13'h0, s.filterOn, 2'h0};
					tmr_pkg::OFS_STAT: next_s.rdata = {14'h0, s.firstCap,
						s.st != tmr_pkg::CH_IDLE};
					tmr_pkg::OFS_CNT: next_s.rdata = s.counter;
					tmr_pkg::OFS_DATA: next_s.rdata = s.data;
					tmr_pkg::OFS_PRESC: next_s.rdata = s.presc;
					tmr_pkg::OFS_IRQ: next_s.rdata = {13'h0, s.irqStat};
					tmr_pkg::OFS_MASK: next_s.rdata = {13'h0, s.irqMask};
					default: next_s.rdata = tmr_pkg::ZERO16;
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.mode <= tmr_pkg::MODE_RESET; // [R11]
			s.presc <= tmr_pkg::PRESC_RESET;
		end
		else
			s <= next_s;
	end

	assign readData = s.rdata;
	assign channelEnableStatus = s.st != tmr_pkg::CH_IDLE;
	assign channelInterrupt = |(s.irqStat & s.irqMask);

	// checks
	sequence start_write;
		ce && wrCtrl && busReq.wdata[tmr_pkg::C_START] && !busReq.wdata[tmr_pkg::C_STOP];
	endsequence
	sequence capture_hit;
		ce && s.st == tmr_pkg::CH_RUN && md == tmr_pkg::MD_CAPTURE && validEdge
			&& !(wrCtrl && busReq.wdata[tmr_pkg::C_STOP]);
	endsequence
	sequence trigger_hit;
		ce && s.st == tmr_pkg::CH_WAIT && cntPulse && !wrCtrl;
	endsequence

	a_start_enables: assert property (@(posedge mclk) disable iff (!rst_b) // [R1]
		start_write |=> channelEnableStatus)
		else $error("start write did not enable channel");
	a_counter_holds: assert property (@(posedge mclk) disable iff (!rst_b) // [R2]
		(s.st == tmr_pkg::CH_WAIT && !cntPulse) |=> $stable(s.counter))
		else $error("counter moved before trigger");
	a_trigger_zero: assert property (@(posedge mclk) disable iff (!rst_b) // [R3]
		(trigger_hit and md == tmr_pkg::MD_CAPTURE)
		|=> s.counter == 16'h0000 && s.st == tmr_pkg::CH_RUN)
		else $error("trigger did not load zero");
	a_start_irq: assert property (@(posedge mclk) disable iff (!rst_b) // [R4]
		(trigger_hit and s.mode[tmr_pkg::M_MD0]) |=> s.irqStat[tmr_pkg::I_START])
		else $error("start interrupt missing");
	a_capture_copy: assert property (@(posedge mclk) disable iff (!rst_b) // [R5]
		capture_hit |=> s.data == $past(s.counter) && s.irqStat[tmr_pkg::I_CAPTURE])
		else $error("capture did not copy counter");
	a_capture_restart: assert property (@(posedge mclk) disable iff (!rst_b) // [R6]
		capture_hit |=> s.counter == 16'h0000 && !s.firstCap)
		else $error("counter not restarted after capture");
	a_count_up: assert property (@(posedge mclk) disable iff (!rst_b) // [R18]
		(ce && s.st == tmr_pkg::CH_RUN && md == tmr_pkg::MD_CAPTURE && opEn && !validEdge
			&& !wrCtrl) |=> s.counter == $past(s.counter) + 16'h0001)
		else $error("capture counter did not step by one");
	// each operation-clock enable moves the level one filter stage on
	a_filter_delay: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
		(ce && opEn) |=> s.fltA == $past(s.sync2) && s.fltB == $past(s.fltA))
		else $error("filter stage did not advance");
	a_edge_run_write: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
		(ce && wrMode && s.st != tmr_pkg::CH_IDLE)
		|=> s.mode[7:6] == $past(busReq.wdata[7:6]) && s.mode[15:8] == $past(s.mode[15:8]))
		else $error("mode write while running mishandled");
	a_role_bit_zero: assert property (@(posedge mclk) disable iff (!rst_b) // [R12]
		(CHANNEL == 0 || CHANNEL == 5 || CHANNEL == 7) |-> !s.mode[tmr_pkg::M_ROLE])
		else $error("bit eleven set on channel without it");
	a_first_flag: assert property (@(posedge mclk) disable iff (!rst_b) // [R7]
		(ce && s.st == tmr_pkg::CH_IDLE && wrCtrl && busReq.wdata[tmr_pkg::C_START]
			&& !busReq.wdata[tmr_pkg::C_STOP]) |=> s.firstCap)
		else $error("first capture not marked after start");
	// a stopped channel takes the whole word, less the bit that does not exist here
	a_mode_idle_write: assert property (@(posedge mclk) disable iff (!rst_b) // [R11] [R12]
		(ce && wrMode && s.st == tmr_pkg::CH_IDLE)
		|=> s.mode == ($past(busReq.wdata) & modeWmask))
		else $error("mode write while stopped mishandled");
endmodule
`default_nettype wire

// [verif/pulse_source.sv]
// external pulse source driving the timer capture input
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
	// clock
	input wire logic mclk,
	// driven capture input
	output logic pin
);
	// the source always drives a level, so the input never floats
	initial pin = 1'b0;

	// change the level just after a clock edge, like a synchronous source
	task automatic drive(input logic lvl);
		@(posedge mclk);
		pin <= lvl;
	endtask

	// two rising edges gap cycles apart; the first carries no interval meaning
	task automatic pair(input int gap);
		repeat (2)
		begin
			drive(1'b1);
			repeat (gap / 2 - 1) @(posedge mclk);
			drive(1'b0);
			repeat (gap - gap / 2 - 1) @(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire

// [verif/timer_channel_capture_tb.sv]
// self-checking bench for the capture timer channel
`timescale 1ns/1ps
`default_nettype none
module timer_channel_capture_tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	tmr_pkg::bus_req_t busReq = '0;
	logic [15:0] readData;
	logic captureInputPin;
	logic channelInterrupt;
	logic channelEnableStatus;
	logic [15:0] v;
	logic [15:0] c1;
	int n_mismatch = 0;
	int checks_done = 0;
	int lat0;
	int lat1;

	// 200 mhz clock
	always #2.5 mclk = ~mclk;

	timer_channel_capture #(.CHANNEL(1)) timer_channel_capture_i (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.busReq(busReq),
		.readData(readData),
		.captureInputPin(captureInputPin),
		.channelInterrupt(channelInterrupt),
		.channelEnableStatus(channelEnableStatus)
	);

	pulse_source pulse_source_i (
		.mclk(mclk),
		.pin(captureInputPin)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write; the trailing delay lets the edge's updates land
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		busReq <= {1'b1, 1'b0, a, d};
		@(posedge mclk);
		busReq.wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdreg(input logic [7:0] a);
		@(posedge mclk);
		busReq <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk);
		busReq.rd <= 1'b0;
		#1 v = readData;
	endtask

	task automatic chkrd(input logic [7:0] a, input logic [15:0] exp);
		rdreg(a);
		chk(v, exp);
	endtask

	// cycles from a pin change until the interrupt rises, capped at 40
	task automatic lat(input logic lvl, output int n);
		wr(8'h18, 16'h0007);
		pulse_source_i.drive(lvl);
		n = 0;
		do
		begin
			@(posedge mclk);
			#1 n++;
		end
		while (channelInterrupt !== 1'b1 && n < 40);
	endtask

	task automatic t_reset();
		chk({15'h0000, channelInterrupt}, 16'h0000);
		chkrd(8'h00, 16'h0000);
		chkrd(8'h08, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(8'h14, 16'h33ff);
		chkrd(8'h14, 16'h33ff);
		wr(8'h14, 16'h0000);
		wr(8'h00, 16'h0800);
		chkrd(8'h00, 16'h0800);
		chkrd(8'h24, 16'h0000); // unmapped place reads zero
		$display("test registers done");
	endtask

	task automatic t_capture();
		wr(8'h1c, 16'h0007);
		wr(8'h10, 16'h0001);
		wr(8'h00, 16'h0045);
		wr(8'h04, 16'h0001);
		chk({15'h0000, channelEnableStatus}, 16'h0001);
		chkrd(8'h08, 16'h0003);
		chkrd(8'h18, 16'h0002);
		chk({15'h0000, channelInterrupt}, 16'h0001);
		chkrd(8'h0c, 16'h0004);
		c1 = v;
		chk({15'h0000, c1 < 16'h0010}, 16'h0001);
		chkrd(8'h0c, c1 + 16'h0002);
		wr(8'h18, 16'h0007);
		pulse_source_i.pair(40);
		repeat (8) @(posedge mclk);
		chkrd(8'h10, 16'h0027);
		chkrd(8'h08, 16'h0001);
		chkrd(8'h18, 16'h0001);
		$display("test capture done");
	endtask

	// the filter must only shift detection, by two cycles at the undivided clock
	task automatic t_filter();
		lat(1'b1, lat0);
		lat(1'b0, lat1);
		chk(lat1[15:0], 16'h0028);
		wr(8'h04, 16'h0004);
		lat(1'b1, lat1);
		chk(lat1[15:0] - lat0[15:0], 16'h0002);
		$display("test filter done");
	endtask

	task automatic t_running();
		wr(8'h00, 16'h00c5);
		chkrd(8'h00, 16'h00c5);
		wr(8'h04, 16'h0002);
		chk({15'h0000, channelEnableStatus}, 16'h0000); // stopped
		wr(8'h00, 16'h0004);
		chkrd(8'h00, 16'h0004);
		$display("test running mode write done");
	endtask

	task automatic t_irq();
		wr(8'h1c, 16'h0000);
		chk({15'h0000, channelInterrupt}, 16'h0000);
		chkrd(8'h18, 16'h0001);
		wr(8'h1c, 16'h0001);
		chk({15'h0000, channelInterrupt}, 16'h0001);
		wr(8'h18, 16'h0001);
		chk({15'h0000, channelInterrupt}, 16'h0000);
		$display("test interrupt done");
	endtask

	// extra output A at divide by 4: any eight running cycles hold exactly two enables
	task automatic t_presc();
		wr(8'h14, 16'h0100);
		wr(8'h00, 16'h4004);
		wr(8'h04, 16'h0001);
		repeat (8) @(posedge mclk);
		rdreg(8'h0c);
		c1 = v;
		repeat (6) @(posedge mclk);
		chkrd(8'h0c, c1 + 16'h0002);
		// a low clock enable freezes counter and prescaler alike
		@(posedge mclk);
		ce <= 1'b0;
		repeat (20) @(posedge mclk);
		ce <= 1'b1;
		repeat (5) @(posedge mclk);
		chkrd(8'h0c, c1 + 16'h0004);
		wr(8'h04, 16'h0002);
		$display("test prescaler done");
	endtask

	task automatic results();
		$display("counts: %0d mismatches, %0d checks", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence after three reset cycles
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_capture();
		t_filter();
		t_running();
		t_irq();
		t_presc();
		results();
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#20000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
